// >>> src/smpwm_top.sv
// six-channel motor modulator with avalon register slave
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module smpwm_top (
	input logic sys_clk,
	input logic arst_n,
	input smpwm_pkg::smpwm_avl_req_t avlReq,
	output logic [31:0] avlReadData,
	output logic avlWaitRequest,
	input logic tmrOverflow,
	input logic [5:0] gpioLevel,
	output logic [5:0] pwmOut
);
	logic waitFf;
	logic [31:0] rdDataFf;
	logic [31:0] rdMux;
	logic wrEn;
	logic [7:0] addr;
	logic [31:0] wd;
	logic runFf;
	logic loadFf;
	logic clrFf;
	logic [1:0] modeFf;
	logic groupFf;
	logic typeFf;
	logic srcFf;
	logic [2:0] divFf;
	logic [15:0] perBufFf;
	logic [15:0] perActFf;
	logic [15:0] dutyBufFf [6];
	logic [15:0] dutyActFf [6];
	logic [8:0] dtCountFf;
	logic [3:0] dtEnFf;
	logic [5:0] outSelFf;
	smpwm_pkg::smpwm_guard_t guardFf;
	logic [6:0] prescFf;
	logic [6:0] presMask;
	logic srcPulse;
	logic tick;
	logic [15:0] cntFf;
	logic downFf;
	logic [15:0] nxt_cnt;
	logic nxt_down;
	logic wrap;
	logic periodEnd;
	logic loadDone;
	logic [5:0] rawFf;
	logic [5:0] modeW;
	logic [5:0] prevFf;
	logic [2:0] dtBusyFf;
	logic [2:0] dtEdge;
	logic [2:0] dtHold;
	logic [8:0] dtCntFf [3];
	logic [5:0] dtOut;
	logic [5:0] pwmOutFf;

	function automatic logic isDuty(input logic [7:0] a);
		return a >= smpwm_pkg::OFS_DUTY0 && a <= smpwm_pkg::OFS_DUTY5 && a[1:0] == 2'h0;
	endfunction

	function automatic logic [2:0] dutyIdx(input logic [7:0] a);
		logic [7:0] d;
		d = a - smpwm_pkg::OFS_DUTY0;
		return d[4:2];
	endfunction

	// channels 2..5 borrow duty 0 or 1 in group mode
	function automatic logic [15:0] effDuty(input int i);
		if (groupFf && i >= 2) begin
			return dutyActFf[i % 2];
		end
		return dutyActFf[i];
	endfunction

	assign addr = avlReq.address;
	assign wd = avlReq.writedata;
	assign wrEn = avlReq.write & ~waitFf;
	assign avlWaitRequest = waitFf;
	assign avlReadData = rdDataFf;
	assign pwmOut = pwmOutFf;

	// one wait cycle per access; the answer edge is the second edge of the request
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			waitFf <= 1'b1;
		end else begin
			waitFf <= ~((avlReq.read | avlReq.write) & waitFf);
		end
	end

	always_comb begin
		rdMux = 32'h0000_0000;
		if (addr == smpwm_pkg::OFS_CTRL) begin
			rdMux[smpwm_pkg::CTRL_RUN] = runFf;
			rdMux[smpwm_pkg::CTRL_LOAD] = loadFf;
			rdMux[smpwm_pkg::CTRL_CLR] = clrFf;
		end else if (addr == smpwm_pkg::OFS_CONF) begin
			rdMux[7:0] = {divFf, srcFf, typeFf, groupFf, modeFf};
		end else if (addr == smpwm_pkg::OFS_PERIOD) begin
			rdMux[15:0] = perBufFf;
		end else if (isDuty(addr)) begin
			rdMux[15:0] = dutyBufFf[dutyIdx(addr)];
		end else if (addr == smpwm_pkg::OFS_DTCNT) begin
			rdMux[8:0] = dtCountFf;
		end else if (addr == smpwm_pkg::OFS_DTEN) begin
			rdMux[3:0] = dtEnFf;
		end else if (addr == smpwm_pkg::OFS_GUARD) begin
			rdMux[0] = guardFf == smpwm_pkg::GUARD_OPEN;
		end else if (addr == smpwm_pkg::OFS_STATUS) begin
			rdMux[15:0] = cntFf;
			rdMux[smpwm_pkg::STAT_DOWN] = downFf;
			rdMux[smpwm_pkg::STAT_WAVE +: 6] = rawFf;
		end else if (addr == smpwm_pkg::OFS_OUTSEL) begin
			rdMux[5:0] = outSelFf;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdDataFf <= 32'h0000_0000;
		end else if (avlReq.read & waitFf) begin
			rdDataFf <= rdMux;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			runFf <= 1'b0;
		end else if (wrEn && addr == smpwm_pkg::OFS_CTRL) begin
			runFf <= wd[smpwm_pkg::CTRL_RUN];
		end
	end

	// set wins over completion: a late request waits for the next period end
	assign loadDone = loadFf & (periodEnd | ~runFf);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			loadFf <= 1'b0;
		end else if (wrEn && addr == smpwm_pkg::OFS_CTRL && wd[smpwm_pkg::CTRL_LOAD]) begin
			loadFf <= 1'b1;
		end else if (loadDone) begin
			loadFf <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			clrFf <= 1'b0;
		end else begin
			clrFf <= wrEn && addr == smpwm_pkg::OFS_CTRL && wd[smpwm_pkg::CTRL_CLR];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			modeFf <= smpwm_pkg::MODE_INDEP;
			groupFf <= 1'b0;
			typeFf <= 1'b0;
			srcFf <= 1'b0;
			divFf <= 3'h0;
		end else if (wrEn && addr == smpwm_pkg::OFS_CONF) begin
			modeFf <= wd[smpwm_pkg::CONF_MODE +: 2];
			groupFf <= wd[smpwm_pkg::CONF_GROUP];
			typeFf <= wd[smpwm_pkg::CONF_TYPE];
			srcFf <= wd[smpwm_pkg::CONF_SRC];
			divFf <= wd[smpwm_pkg::CONF_DIV +: 3];
		end
	end

	// buffers take writes at any time; the active copies move only on load
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			perBufFf <= smpwm_pkg::PERIOD_RST;
			perActFf <= smpwm_pkg::PERIOD_RST;
			for (int i = 0; i < 6; i++) begin
				dutyBufFf[i] <= smpwm_pkg::DUTY_RST;
				dutyActFf[i] <= smpwm_pkg::DUTY_RST;
			end
		end else begin
			if (wrEn && addr == smpwm_pkg::OFS_PERIOD) begin
				perBufFf <= wd[15:0];
			end
			if (wrEn && isDuty(addr)) begin
				dutyBufFf[dutyIdx(addr)] <= wd[15:0];
			end
			if (loadDone) begin
				perActFf <= perBufFf;
				for (int i = 0; i < 6; i++) begin
					dutyActFf[i] <= dutyBufFf[i];
				end
			end
		end
	end

	// key pair opens the guard; the very next write of any kind closes it
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			guardFf <= smpwm_pkg::GUARD_LOCKED;
		end else if (wrEn) begin
			case (guardFf)
				smpwm_pkg::GUARD_LOCKED: begin
					if (addr == smpwm_pkg::OFS_GUARD && wd[7:0] == smpwm_pkg::GUARD_KEY1) begin
						guardFf <= smpwm_pkg::GUARD_HALF;
					end
				end
				smpwm_pkg::GUARD_HALF: begin
					if (addr == smpwm_pkg::OFS_GUARD && wd[7:0] == smpwm_pkg::GUARD_KEY2) begin
						guardFf <= smpwm_pkg::GUARD_OPEN;
					end else begin
						guardFf <= smpwm_pkg::GUARD_LOCKED;
					end
				end
				default: begin
					guardFf <= smpwm_pkg::GUARD_LOCKED;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			dtCountFf <= smpwm_pkg::DTCNT_RST;
			dtEnFf <= smpwm_pkg::DTEN_RST;
		end else if (wrEn && guardFf == smpwm_pkg::GUARD_OPEN) begin
			if (addr == smpwm_pkg::OFS_DTCNT) begin
				dtCountFf <= wd[8:0];
			end else if (addr == smpwm_pkg::OFS_DTEN) begin
				dtEnFf <= wd[3:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			outSelFf <= smpwm_pkg::OUTSEL_RST;
		end else if (wrEn && addr == smpwm_pkg::OFS_OUTSEL) begin
			outSelFf <= wd[5:0];
		end
	end

	// prescaler counts source pulses; 2**div pulses make one tick
	assign presMask = 7'((8'h01 << divFf) - 8'h01);
	assign srcPulse = srcFf ? tmrOverflow : 1'b1;
	assign tick = runFf & srcPulse & ((prescFf & presMask) == presMask);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prescFf <= 7'h00;
		end else if (clrFf || !runFf) begin
			prescFf <= 7'h00;
		end else if (srcPulse) begin
			prescFf <= tick ? 7'h00 : prescFf + 7'h01;
		end
	end

	always_comb begin
		nxt_cnt = cntFf + 16'h0001;
		nxt_down = 1'b0;
		wrap = 1'b0;
		if (!typeFf) begin
			if (cntFf >= perActFf) begin
				nxt_cnt = 16'h0000;
				wrap = 1'b1;
			end
		end else if (!downFf) begin
			if (perActFf == 16'h0000) begin
				nxt_cnt = 16'h0000;
				wrap = 1'b1;
			end else if (cntFf >= perActFf) begin
				nxt_cnt = cntFf - 16'h0001;
				nxt_down = 1'b1;
			end
		end else if (cntFf <= 16'h0001) begin
			nxt_cnt = 16'h0000;
			wrap = 1'b1;
		end else begin
			nxt_cnt = cntFf - 16'h0001;
			nxt_down = 1'b1;
		end
	end
	assign periodEnd = tick & wrap;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cntFf <= 16'h0000;
			downFf <= 1'b0;
		end else if (clrFf) begin
			cntFf <= 16'h0000;
			downFf <= 1'b0;
		end else if (tick) begin
			cntFf <= nxt_cnt;
			downFf <= nxt_down;
		end
	end

	// idle at zero primes each wave so the first period starts high unless its duty is zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rawFf <= 6'h00;
		end else begin
			for (int i = 0; i < 6; i++) begin
				if (!runFf) begin
					if (cntFf == 16'h0000 || clrFf) begin
						rawFf[i] <= effDuty(i) != 16'h0000;
					end
				end else if (tick && !typeFf) begin
					if (nxt_cnt == effDuty(i)) begin
						rawFf[i] <= 1'b0;
					end else if (nxt_cnt == 16'h0000) begin
						rawFf[i] <= 1'b1;
					end
				end else if (tick) begin
					if (nxt_cnt == effDuty(i) && nxt_down) begin
						rawFf[i] <= 1'b1;
					end else if (nxt_cnt == effDuty(i) && effDuty(i) < perActFf) begin
						rawFf[i] <= 1'b0;
					end
				end
			end
		end
	end

	always_comb begin
		for (int p = 0; p < 3; p++) begin
			modeW[2*p] = rawFf[2*p] & runFf;
			if (modeFf == smpwm_pkg::MODE_COMPL) begin
				modeW[2*p+1] = ~rawFf[2*p] & runFf;
			end else if (modeFf == smpwm_pkg::MODE_SYNC) begin
				modeW[2*p+1] = rawFf[2*p] & runFf;
			end else begin
				modeW[2*p+1] = rawFf[2*p+1] & runFf;
			end
		end
	end

	// the edge cycle itself is held too, so a rising output never leaks one cycle early
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			dtEdge[p] = modeFf == smpwm_pkg::MODE_COMPL && dtEnFf[p]
				&& modeW[2*p+:2] != prevFf[2*p+:2];
			dtHold[p] = dtEdge[p] | dtBusyFf[p];
		end
	end

	// a pair edge restarts its counter; edge cycle plus count cycles keep the pair low
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prevFf <= 6'h00;
			dtBusyFf <= 3'h0;
			for (int p = 0; p < 3; p++) begin
				dtCntFf[p] <= 9'h000;
			end
		end else begin
			prevFf <= modeW;
			for (int p = 0; p < 3; p++) begin
				if (modeFf != smpwm_pkg::MODE_COMPL || !dtEnFf[p]) begin
					dtBusyFf[p] <= 1'b0;
				end else if (dtEdge[p]) begin
					dtBusyFf[p] <= dtCountFf != 9'h000;
					dtCntFf[p] <= dtCountFf - 9'h001;
				end else if (dtBusyFf[p]) begin
					if (dtCntFf[p] == 9'h000) begin
						dtBusyFf[p] <= 1'b0;
					end else begin
						dtCntFf[p] <= dtCntFf[p] - 9'h001;
					end
				end
			end
		end
	end

	// mask, fault and polarity stages are not built; the mux follows dead time
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			dtOut[i] = modeW[i] & ~dtHold[i/2];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pwmOutFf <= 6'h00;
		end else begin
			pwmOutFf <= (outSelFf & dtOut) | (~outSelFf & gpioLevel);
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	sequence s_clrWrite;
		wrEn && addr == smpwm_pkg::OFS_CTRL && wd[smpwm_pkg::CTRL_CLR];
	endsequence
	sequence s_clrDone;
		clrFf ##1 (cntFf == 16'h0000 && !downFf);
	endsequence

	chk_clear_to_zero: assert property (s_clrWrite |=> s_clrDone)
		else $error("counter clear did not zero the counter");

	chk_idle_stays: assert property (!runFf && !clrFf |=> $stable(cntFf))
		else $error("counter moved while idle");

	chk_edge_wrap: assert property (tick && !typeFf && cntFf >= perActFf && !clrFf
		|=> cntFf == 16'h0000)
		else $error("edge counter did not wrap at period");

	chk_center_turn: assert property (tick && typeFf && !downFf && !clrFf
		&& perActFf != 16'h0000 && cntFf == perActFf |=> downFf)
		else $error("center counter did not turn down at period");

	chk_load_apply: assert property (loadFf && periodEnd
		&& !(wrEn && addr == smpwm_pkg::OFS_CTRL)
		|=> !loadFf && perActFf == $past(perBufFf))
		else $error("load did not apply at period end");

	chk_guard_block: assert property (wrEn && addr == smpwm_pkg::OFS_DTCNT
		&& guardFf != smpwm_pkg::GUARD_OPEN |=> $stable(dtCountFf))
		else $error("dead-time count written without guard");

	chk_compl_pair: assert property (runFf && modeFf == smpwm_pkg::MODE_COMPL
		|-> modeW[1] == !modeW[0])
		else $error("complementary partner not inverted");

	chk_dead_low: assert property (dtHold[0]
		|=> pwmOut[1:0] == ($past(~outSelFf[1:0]) & $past(gpioLevel[1:0])))
		else $error("pair drove high during dead time");

	chk_dead_reload: assert property (modeFf == smpwm_pkg::MODE_COMPL && dtEnFf[0]
		&& modeW[1:0] != prevFf[1:0] |=> dtBusyFf[0] == ($past(dtCountFf) != 9'h000)
		&& dtCntFf[0] == $past(dtCountFf) - 9'h001)
		else $error("dead-time counter not reloaded on edge");

	chk_presc_gap: assert property (tick && divFf >= 3'h2 && !srcFf
		&& !$changed(divFf) |=> !tick [*3])
		else $error("prescaled tick came too soon");
endmodule

// >>> src/smpwm_pkg.sv
// constants and types for the six-channel motor modulator
// Summary of operation
// - counter ticks from system clock or timer overflow, prescaled 1/1 to 1/128
// - one 16-bit period and one 16-bit counter serve all six channels
// - six 16-bit duties, each compared against the shared counter
// - group mode: channels 2,4 use duty 0; channels 3,5 use duty 1
// - raw waves pass mode select, dead time, then pin function multiplexer
// - writing run one starts the counter and waveform generation
// - period and duty buffered; load applies at period end, or at once while run is zero, then self-clears
// - one type bit picks edge-aligned or center-aligned counting
// - edge: count 0 to period, wrap; set at zero, clear at duty
// - edge: frequency clock over period plus one; duty over period plus one
// - center: count up to period, then down to zero, repeating
// - center: clear on up-count duty match, set on down-count match
// - center: frequency clock over twice period; high fraction duty over period
// - pair mode 00: all six channels independent
// - pair mode 01: odd channels output inverse of even partner
// - each pair has a 9-bit dead-time down-counter delaying rising edges
// - dead time enabled per pair, effective only in complementary mode
// - dead-time count and enable writable only after timed-access sequence
// - pair mode 10: odd channels copy their even partner in phase
// - counter-clear zeroes counter, self-clears, reads one while pending
// - run zero keeps the modulator idle; one runs it
package smpwm_pkg;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned DT_W = 9;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CONF = 8'h04;
	localparam logic [7:0] OFS_PERIOD = 8'h08;
	localparam logic [7:0] OFS_DUTY0 = 8'h0C;
	localparam logic [7:0] OFS_DUTY5 = 8'h20;
	localparam logic [7:0] OFS_DTCNT = 8'h24;
	localparam logic [7:0] OFS_DTEN = 8'h28;
	localparam logic [7:0] OFS_GUARD = 8'h2C;
	localparam logic [7:0] OFS_STATUS = 8'h30;
	localparam logic [7:0] OFS_OUTSEL = 8'h34;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_LOAD = 1;
	localparam int CTRL_CLR = 2;
	localparam int CONF_MODE = 0;
	localparam int CONF_GROUP = 2;
	localparam int CONF_TYPE = 3;
	localparam int CONF_SRC = 4;
	localparam int CONF_DIV = 5;
	localparam int STAT_DOWN = 16;
	localparam int STAT_WAVE = 17;
	localparam logic [1:0] MODE_INDEP = 2'h0;
	localparam logic [1:0] MODE_COMPL = 2'h1;
	localparam logic [1:0] MODE_SYNC = 2'h2;
	localparam logic [7:0] GUARD_KEY1 = 8'hAA;
	localparam logic [7:0] GUARD_KEY2 = 8'h55;
	localparam logic [15:0] PERIOD_RST = 16'h0000;
	localparam logic [15:0] DUTY_RST = 16'h0000;
	localparam logic [8:0] DTCNT_RST = 9'h000;
	localparam logic [3:0] DTEN_RST = 4'h0;
	localparam logic [5:0] OUTSEL_RST = 6'h00;
	typedef enum logic [1:0] {GUARD_LOCKED, GUARD_HALF, GUARD_OPEN} smpwm_guard_t;
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} smpwm_avl_req_t;
endpackage

// >>> bench/smpwm_bridge_model.sv
// half-bridge model of the motor stage driven by the six gate outputs
`timescale 1ns/10ps
module smpwm_bridge_model (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic watch,
	input wire logic [5:0] gate,
	output logic [2:0] phaseLevel_ff,
	output logic [15:0] shootCount_ff
);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			phaseLevel_ff <= 3'h0;
		end else begin
			// a leg with both switches off floats; inductor current keeps the last level
			for (int i = 0; i < 3; i++) begin
				if (gate[2*i] && !gate[2*i+1])
					phaseLevel_ff[i] <= 1'b1;
				else if (!gate[2*i] && gate[2*i+1])
					phaseLevel_ff[i] <= 1'b0;
			end
		end
	end

	// both switches of one leg on shorts the supply; only meaningful in complementary drive
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			shootCount_ff <= 16'h0000;
		else if (watch && ((gate[0] && gate[1]) || (gate[2] && gate[3]) || (gate[4] && gate[5])))
			shootCount_ff <= shootCount_ff + 16'h0001;
	end
endmodule

// >>> bench/six_channel_motor_pwm_bench.sv
// self-checking bench for the six-channel motor modulator
`timescale 1ns/10ps
module six_channel_motor_pwm_bench;
	typedef struct {
		logic [7:0] conf;
		int hi [6];
	} smpwm_row_t;

	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	smpwm_pkg::smpwm_avl_req_t avlReq = '0;
	logic [31:0] avlReadData;
	logic avlWaitRequest;
	logic tmrOverflow = 1'b0;
	logic [5:0] gpioLevel = 6'h00;
	logic [5:0] pwmOut;
	logic watch = 1'b0;
	logic [15:0] shootCount;
	logic [31:0] rd;
	int nMismatch = 0;
	int nTests = 0;
	// period 9, duties 3/6/2; high cycles counted over 360 cycles
	smpwm_row_t rows [9] = '{
		'{8'h00, '{108, 216, 72, 72, 72, 72}},
		'{8'h04, '{108, 216, 108, 216, 108, 216}},
		'{8'h01, '{108, 252, 72, 288, 72, 288}},
		'{8'h02, '{108, 108, 72, 72, 72, 72}},
		'{8'h03, '{108, 216, 72, 72, 72, 72}},
		'{8'h08, '{120, 240, 80, 80, 80, 80}},
		'{8'h40, '{108, 216, 72, 72, 72, 72}},
		'{8'h10, '{108, 216, 72, 72, 72, 72}},
		'{8'h09, '{120, 240, 80, 280, 80, 280}}
	};

	smpwm_top smpwm_top_i (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.avlReq(avlReq),
		.avlReadData(avlReadData),
		.avlWaitRequest(avlWaitRequest),
		.tmrOverflow(tmrOverflow),
		.gpioLevel(gpioLevel),
		.pwmOut(pwmOut)
	);

	smpwm_bridge_model smpwm_bridge_model_i (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.watch(watch),
		.gate(pwmOut),
		.phaseLevel_ff(),
		.shootCount_ff(shootCount)
	);

	always #5 sys_clk = ~sys_clk;
	// overflow every second cycle, so the timer source acts as divide by two
	always @(posedge sys_clk) tmrOverflow <= ~tmrOverflow;

	task automatic results();
		if (nMismatch == 0 && nTests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		nTests++;
		if (got !== exp) begin
			nMismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic xfer(logic wr, logic [7:0] adr, logic [31:0] wd);
		int n = 0;
		@(posedge sys_clk);
		avlReq <= '{read: !wr, write: wr, address: adr, writedata: wd};
		do begin
			@(posedge sys_clk);
			n++;
		end while (avlWaitRequest !== 1'b0 && n < 50);
		rd = avlReadData;
		avlReq <= '0;
		if (n >= 50) begin
			nMismatch++;
			results();
		end
	endtask

	task automatic waitLoad();
		int n = 0;
		do begin
			xfer(1'b0, smpwm_pkg::OFS_CTRL, 32'h0000_0000);
			n++;
		end while (rd[smpwm_pkg::CTRL_LOAD] !== 1'b0 && n < 100);
		if (n >= 100) begin
			nMismatch++;
			results();
		end
	endtask

	task automatic measure(int exp [6]);
		int cnt [6] = '{default: 0};
		repeat (80) @(posedge sys_clk);
		repeat (360) begin
			@(posedge sys_clk);
			for (int i = 0; i < 6; i++)
				if (pwmOut[i] === 1'b1)
					cnt[i]++;
		end
		for (int i = 0; i < 6; i++)
			check($sformatf("high cycles ch%0d", i), 32'(exp[i]), 32'(cnt[i]));
	endtask

	task automatic setup(logic [7:0] conf);
		xfer(1'b1, smpwm_pkg::OFS_CTRL, 32'h0000_0000);
		xfer(1'b1, smpwm_pkg::OFS_CTRL, 32'h0000_0004);
		xfer(1'b1, smpwm_pkg::OFS_CONF, {24'h00_0000, conf});
		xfer(1'b1, smpwm_pkg::OFS_PERIOD, 32'h0000_0009);
		for (int i = 0; i < 6; i++)
			xfer(1'b1, smpwm_pkg::OFS_DUTY0 + 8'(4 * i),
				i == 0 ? 32'h0000_0003 : (i == 1 ? 32'h0000_0006 : 32'h0000_0002));
		xfer(1'b1, smpwm_pkg::OFS_CTRL, 32'h0000_0002);
		waitLoad();
		xfer(1'b1, smpwm_pkg::OFS_OUTSEL, 32'h0000_003F);
		xfer(1'b1, smpwm_pkg::OFS_CTRL, 32'h0000_0001);
	endtask

	task automatic guardWrite(logic [7:0] adr, logic [31:0] wd);
		xfer(1'b1, smpwm_pkg::OFS_GUARD, 32'h0000_00AA);
		xfer(1'b1, smpwm_pkg::OFS_GUARD, 32'h0000_0055);
		xfer(1'b1, adr, wd);
	endtask

	initial begin
		repeat (5) @(posedge sys_clk);
		arst_n <= 1'b1;
		for (int r = 0; r < 9; r++) begin
			setup(rows[r].conf);
			measure(rows[r].hi);
		end
		// reset in mid-run
		@(posedge sys_clk);
		arst_n <= 1'b0;
		@(posedge sys_clk);
		check("pwmOut in reset", 32'h0000_0000, 32'(pwmOut));
		check("waitRequest in reset", 32'h0000_0001, 32'(avlWaitRequest));
		arst_n <= 1'b1;
		xfer(1'b1, 8'hFC, 32'hFFFF_FFFF);
		for (int a = 0; a <= 'h34; a += 4) begin
			xfer(1'b0, 8'(a), 32'h0000_0000);
			check($sformatf("register %h after reset", a), 32'h0000_0000, rd);
		end
		xfer(1'b0, 8'hFC, 32'h0000_0000);
		check("unmapped read", 32'h0000_0000, rd);
		xfer(1'b1, smpwm_pkg::OFS_DTCNT, 32'h0000_0001);
		xfer(1'b0, smpwm_pkg::OFS_DTCNT, 32'h0000_0000);
		check("unguarded dead time", 32'h0000_0000, rd);
		guardWrite(smpwm_pkg::OFS_DTCNT, 32'h0000_0001);
		guardWrite(smpwm_pkg::OFS_DTEN, 32'h0000_0001);
		xfer(1'b0, smpwm_pkg::OFS_DTCNT, 32'h0000_0000);
		check("guarded dead time", 32'h0000_0001, rd);
		// dead time 2 cycles on pair 0 only
		watch <= 1'b1;
		setup(8'h01);
		measure('{36, 180, 72, 288, 72, 288});
		watch <= 1'b0;
		check("shoot-through cycles", 32'h0000_0000, 32'(shootCount));
		setup(8'h00);
		measure(rows[0].hi);
		xfer(1'b1, smpwm_pkg::OFS_DUTY0, 32'h0000_0005);
		measure(rows[0].hi);
		xfer(1'b1, smpwm_pkg::OFS_CTRL, 32'h0000_0003);
		xfer(1'b0, smpwm_pkg::OFS_CTRL, 32'h0000_0000);
		check("load pending", 32'h0000_0001, 32'(rd[smpwm_pkg::CTRL_LOAD]));
		waitLoad();
		measure('{180, 216, 72, 72, 72, 72});
		xfer(1'b1, smpwm_pkg::OFS_CTRL, 32'h0000_0000);
		xfer(1'b1, smpwm_pkg::OFS_CTRL, 32'h0000_0004);
		xfer(1'b0, smpwm_pkg::OFS_STATUS, 32'h0000_0000);
		check("counter after clear", 32'h0000_0000, 32'(rd[15:0]));
		xfer(1'b0, smpwm_pkg::OFS_CTRL, 32'h0000_0000);
		check("clear bit", 32'h0000_0000, 32'(rd[smpwm_pkg::CTRL_CLR]));
		gpioLevel <= 6'h2A;
		xfer(1'b1, smpwm_pkg::OFS_OUTSEL, 32'h0000_000F);
		repeat (3) @(posedge sys_clk);
		check("idle outputs", 32'h0000_0020, 32'(pwmOut));
		xfer(1'b1, smpwm_pkg::OFS_OUTSEL, 32'h0000_0000);
		repeat (3) @(posedge sys_clk);
		check("pin function", 32'h0000_002A, 32'(pwmOut));
		results();
	end
endmodule
